/* rtl/pcs_socket_if.sv */
// Purpose: single socket card interface with index/data register port
// Assumes: all inputs synchronous to clock; clock is the card bus clock
// Notes: data bytes pass through external buffers, not this block
`timescale 1ns/10ps

module pcs_socket_if
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  input wire logic io_wr,
  output logic [7:0] io_rdata,
  input wire logic cyc_req,
  input wire pcs_cyc_req_t cyc_info,
  output logic cyc_busy,
  output logic cyc_done,
  output logic cyc_miss,
  input wire logic [3:0] sys_upper_in,
  output logic [3:0] sys_upper_addr,
  output logic [11:0] sys_low_addr,
  output logic [1:0] card_upper_addr_hi,
  output logic [7:0] card_upper_addr_mid,
  output logic buffer_enable_n,
  output logic buffer_direction,
  output logic [1:0] byte_select_n,
  output logic attr_space_select_n,
  output logic mem_rd_strobe_out,
  output logic mem_rd_strobe_oe,
  output logic mem_wr_strobe_out,
  output logic mem_wr_strobe_oe,
  input wire logic [2:0] card_detect_in,
  output logic card_reset_out,
  input wire logic card_ready_busy,
  input wire logic write_protect_in,
  input wire logic [1:0] voltage_sense,
  input wire logic card_wait_n,
  output logic card_irq,
  output logic supply_low_en_n,
  output logic supply_high_en_n,
  output logic prog_voltage_en
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] index_sel;
  logic [7:0] power_ctl;
  logic [7:0] route_ctl;
  logic [7:0] win_ctl;
  logic [7:0] win_start;
  logic [7:0] win_stop;
  logic [13:0] win_off;
  logic [7:0] wait_ctl;
  logic change_flag;
  logic [2:0] detect_q;
  logic card_present;
  logic powered;
  logic io_card;
  logic legacy_timing;
  logic data_wr;
  logic index_wr;
  logic change_clr;
  logic [7:0] status_byte;

  assign data_wr = clk_en && io_wr && (io_addr == PCS_PORT_DATA);
  assign index_wr = clk_en && io_wr && (io_addr == PCS_PORT_INDEX);
  assign change_clr = data_wr && (index_sel == PCS_IX_CHANGE) &&
                      io_wdata[0];
  assign card_present = (card_detect_in == 3'h0);
  // either supply on counts as powered; strobes float otherwise
  assign powered = !power_ctl[PCS_PWR_LOW] || !power_ctl[PCS_PWR_HIGH];
  assign io_card = power_ctl[PCS_PWR_IOCARD];
  assign legacy_timing = (wait_ctl[3:0] >= PCS_LEGACY_WS) &&
                         (wait_ctl[7:4] >= PCS_LEGACY_WS);

  // index survives data accesses so one register can be polled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      index_sel <= 8'h00;
    end else if (index_wr) begin
      index_sel <= io_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_ctl <= PCS_RST_POWER;
      route_ctl <= PCS_RST_ROUTE;
      win_ctl <= PCS_RST_WIN_CTL;
      win_start <= PCS_RST_WIN_START;
      win_stop <= PCS_RST_WIN_STOP;
      win_off <= PCS_RST_WIN_OFF;
      wait_ctl <= PCS_RST_WAIT;
    end else if (data_wr) begin
      case (index_sel)
        PCS_IX_POWER: power_ctl <= io_wdata;
        PCS_IX_ROUTE: route_ctl <= io_wdata;
        PCS_IX_WIN_CTL: win_ctl <= io_wdata;
        PCS_IX_WIN_START: win_start <= io_wdata;
        PCS_IX_WIN_STOP: win_stop <= io_wdata;
        PCS_IX_WIN_OFF_LO: win_off[7:0] <= io_wdata;
        PCS_IX_WIN_OFF_HI: win_off[13:8] <= io_wdata[5:0];
        PCS_IX_WAIT: wait_ctl <= io_wdata;
        default: begin
        end
      endcase
    end
  end

  // insertion or removal is sticky; a change in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // a card already seated at reset is reported once as an insertion
      detect_q <= 3'h7;
      change_flag <= 1'b0;
    end else if (clk_en) begin
      detect_q <= card_detect_in;
      if (detect_q != card_detect_in) begin
        change_flag <= 1'b1;
      end else if (change_clr) begin
        change_flag <= 1'b0;
      end
    end
  end

  // status bits 0 to 2 are live pin levels, not latched copies; bit 5 is the latched change flag
  always_comb begin
    status_byte = 8'h00;
    status_byte[0] = card_present;
    status_byte[1] = card_ready_busy;
    status_byte[2] = write_protect_in;
    status_byte[3] = powered;
    status_byte[4] = legacy_timing;
    status_byte[5] = change_flag;
  end

  // read data is registered and holds until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (clk_en && io_rd) begin
      if (io_addr == PCS_PORT_INDEX) begin
        io_rdata <= index_sel;
      end else if (io_addr == PCS_PORT_DATA) begin
        case (index_sel)
          PCS_IX_IDENT: io_rdata <= PCS_IDENT_VALUE;
          PCS_IX_STATUS: io_rdata <= status_byte;
          PCS_IX_POWER: io_rdata <= power_ctl;
          PCS_IX_ROUTE: io_rdata <= route_ctl;
          PCS_IX_CHANGE: io_rdata <= {7'h00, change_flag};
          PCS_IX_WIN_CTL: io_rdata <= win_ctl;
          PCS_IX_WIN_START: io_rdata <= win_start;
          PCS_IX_WIN_STOP: io_rdata <= win_stop;
          PCS_IX_WIN_OFF_LO: io_rdata <= win_off[7:0];
          PCS_IX_WIN_OFF_HI: io_rdata <= {2'h0, win_off[13:8]};
          PCS_IX_WAIT: io_rdata <= wait_ctl;
          PCS_IX_VSENSE: io_rdata <= {6'h00, voltage_sense};
          default: io_rdata <= PCS_UNMAPPED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // power, reset and dual-use card status
  // ----------------------------------------------------------------
  assign supply_low_en_n = power_ctl[PCS_PWR_LOW];
  assign supply_high_en_n = power_ctl[PCS_PWR_HIGH];
  assign prog_voltage_en = power_ctl[PCS_PWR_PROG];
  assign card_reset_out = power_ctl[PCS_PWR_RESET];
  // ready/busy low means an I/O card requests service
  assign card_irq = io_card && !card_ready_busy;

  // ----------------------------------------------------------------
  // window decode and translation
  // ----------------------------------------------------------------
  pcs_cyc_req_t req_q;
  logic [7:0] host_page;
  logic mem_hit;
  logic hit;
  logic wide;
  logic [13:0] card_page;

  assign host_page = cyc_info.addr[19:12];
  assign mem_hit = win_ctl[PCS_WC_EN] &&
                   (host_page >= PCS_HOST_PAGE_LO) &&
                   (host_page <= PCS_HOST_PAGE_HI) &&
                   (host_page >= win_start) &&
                   (host_page <= win_stop);
  assign hit = card_present && powered &&
               (cyc_info.io ? power_ctl[PCS_PWR_IOEN] : mem_hit);
  // i/o cards report 16-bit size on the write protect line
  assign wide = cyc_info.io ?
                (win_ctl[PCS_WC_IO_WIDE] || (io_card && write_protect_in)) :
                win_ctl[PCS_WC_WIDE];
  // 4 KByte pages: only address bits 25:12 are offset
  assign card_page = {6'h00, host_page} + win_off;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  pcs_state_t state;
  logic [4:0] ws_count;
  logic [3:0] extra_ws;
  logic [4:0] cyc_len;
  logic wide_q;
  logic [13:0] page_q;

  always_comb begin
    extra_ws = req_q.io ? wait_ctl[3:0] : wait_ctl[7:4];
    if (wide_q && (win_ctl[7:4] > extra_ws)) begin
      extra_ws = win_ctl[7:4];
    end
  end

  // five bits so 3 plus 15 wait states cannot wrap to a short cycle
  assign cyc_len = {1'b0, PCS_CYC_BASE} + {1'b0, extra_ws};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= PCS_ST_IDLE;
      ws_count <= 5'h00;
      req_q <= '0;
      wide_q <= 1'b0;
      page_q <= 14'h0000;
      cyc_miss <= 1'b0;
    end else if (clk_en) begin
      cyc_miss <= 1'b0;
      case (state)
        PCS_ST_IDLE: begin
          if (cyc_req && hit) begin
            state <= PCS_ST_ACTIVE;
            req_q <= cyc_info;
            wide_q <= wide;
            page_q <= card_page;
            ws_count <= 5'h01;
          end else if (cyc_req) begin
            cyc_miss <= 1'b1;
          end
        end
        PCS_ST_ACTIVE: begin
          // wait stretches the cycle; both run together, so the max counts
          if (ws_count < 5'h1f) begin
            ws_count <= ws_count + 5'h01;
          end
          if ((ws_count >= cyc_len) && card_wait_n) begin
            state <= PCS_ST_DONE;
          end
        end
        PCS_ST_DONE: begin
          state <= PCS_ST_IDLE;
        end
        default: state <= PCS_ST_IDLE;
      endcase
    end
  end

  logic active;
  logic accept;
  assign active = (state == PCS_ST_ACTIVE);
  assign accept = (state == PCS_ST_IDLE) && cyc_req && hit;
  assign cyc_busy = !(state == PCS_ST_IDLE);
  assign cyc_done = (state == PCS_ST_DONE);

  // ----------------------------------------------------------------
  // card pins
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      card_upper_addr_hi <= 2'h0;
      card_upper_addr_mid <= 8'h00;
      sys_low_addr <= 12'h000;
    end else if (clk_en && accept) begin
      card_upper_addr_hi <= card_page[13:12];
      card_upper_addr_mid <= card_page[7:0];
      sys_low_addr <= cyc_info.addr[11:0];
    end
  end

  // per-bit choice between system use and card address 23..20
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_upper
      assign sys_upper_addr[gi] = route_ctl[gi] ? page_q[8 + gi] :
                                  sys_upper_in[gi];
    end
  endgenerate

  // buffers stay off between cycles so the shared bus is isolated
  assign buffer_enable_n = !active;
  assign buffer_direction = active && req_q.write;
  always_comb begin
    byte_select_n = 2'b11;
    if (active) begin
      if (wide_q) begin
        byte_select_n = 2'b00;
      end else if (req_q.addr[0]) begin
        byte_select_n = 2'b01;
      end else begin
        byte_select_n = 2'b10;
      end
    end
  end
  assign attr_space_select_n = !(active && !req_q.io &&
                                 win_ctl[PCS_WC_ATTR]);

  // routed strobes float when socket is unpowered or not routed
  assign mem_rd_strobe_oe = route_ctl[PCS_RT_STROBE] && powered;
  assign mem_wr_strobe_oe = route_ctl[PCS_RT_STROBE] && powered;
  assign mem_rd_strobe_out = !(active && !req_q.io && !req_q.write);
  assign mem_wr_strobe_out = !(active && !req_q.io && req_q.write);

endmodule

/* rtl/pcs_pkg.sv */
// Purpose: shared constants and types for the card socket interface
// Assumes: clock is the card bus clock that sets the cycle length
// Notes: indexed register numbers, field positions and reset values
package pcs_pkg;
  // host i/o ports
  localparam logic [15:0] PCS_PORT_INDEX = 16'h03e0;
  localparam logic [15:0] PCS_PORT_DATA = 16'h03e1;
  // indexed registers
  localparam logic [7:0] PCS_IX_IDENT = 8'h00;
  localparam logic [7:0] PCS_IX_STATUS = 8'h01;
  localparam logic [7:0] PCS_IX_POWER = 8'h02;
  localparam logic [7:0] PCS_IX_ROUTE = 8'h03;
  localparam logic [7:0] PCS_IX_CHANGE = 8'h04;
  localparam logic [7:0] PCS_IX_WIN_CTL = 8'h05;
  localparam logic [7:0] PCS_IX_WIN_START = 8'h06;
  localparam logic [7:0] PCS_IX_WIN_STOP = 8'h07;
  localparam logic [7:0] PCS_IX_WIN_OFF_LO = 8'h08;
  localparam logic [7:0] PCS_IX_WIN_OFF_HI = 8'h09;
  localparam logic [7:0] PCS_IX_WAIT = 8'h0a;
  localparam logic [7:0] PCS_IX_VSENSE = 8'h1f;
  // arbitrary identity value
  localparam logic [7:0] PCS_IDENT_VALUE = 8'h00a5;
  localparam logic [7:0] PCS_UNMAPPED = 8'h00ff;
  // power register fields
  localparam int PCS_PWR_LOW = 0;
  localparam int PCS_PWR_HIGH = 1;
  localparam int PCS_PWR_PROG = 2;
  localparam int PCS_PWR_RESET = 3;
  localparam int PCS_PWR_IOCARD = 4;
  localparam int PCS_PWR_IOEN = 5;
  // route register fields
  localparam int PCS_RT_STROBE = 4;
  // window control fields
  localparam int PCS_WC_EN = 0;
  localparam int PCS_WC_WIDE = 1;
  localparam int PCS_WC_ATTR = 2;
  localparam int PCS_WC_IO_WIDE = 3;
  // reset values
  localparam logic [7:0] PCS_RST_POWER = 8'h000b;
  localparam logic [7:0] PCS_RST_ROUTE = 8'h0000;
  localparam logic [7:0] PCS_RST_WIN_CTL = 8'h0000;
  localparam logic [7:0] PCS_RST_WIN_START = 8'h00a0;
  localparam logic [7:0] PCS_RST_WIN_STOP = 8'h00a0;
  localparam logic [13:0] PCS_RST_WIN_OFF = 14'h0000;
  localparam logic [7:0] PCS_RST_WAIT = 8'h0033;
  // host memory window limits, in 4 KByte pages
  localparam logic [7:0] PCS_HOST_PAGE_LO = 8'h00a0;
  localparam logic [7:0] PCS_HOST_PAGE_HI = 8'h00ef;
  // cycle timing
  localparam logic [3:0] PCS_CYC_BASE = 4'h3;
  localparam logic [3:0] PCS_LEGACY_WS = 4'h3;

  typedef struct packed {
    logic [19:0] addr;
    logic io;
    logic write;
  } pcs_cyc_req_t;

  typedef enum logic [2:0] {
    PCS_ST_IDLE = 3'b001,
    PCS_ST_ACTIVE = 3'b010,
    PCS_ST_DONE = 3'b100
  } pcs_state_t;
endpackage

/* verif/pcs_socket_monitor.sv */
// Purpose: port checker for the card socket interface
// Assumes: one clock domain, async active-low reset
// Notes: bound onto the design top
`timescale 1ns/10ps
module pcs_socket_monitor
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cyc_busy,
  input wire logic cyc_done,
  input wire logic cyc_miss,
  input wire logic buffer_enable_n,
  input wire logic buffer_direction,
  input wire logic [1:0] byte_select_n,
  input wire logic mem_rd_strobe_oe,
  input wire logic mem_wr_strobe_oe,
  input wire logic card_ready_busy,
  input wire logic card_wait_n,
  input wire logic card_irq,
  input wire logic supply_low_en_n,
  input wire logic supply_high_en_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence seq_open;
    $fell(buffer_enable_n);
  endsequence
  sequence seq_hold3;
    !buffer_enable_n [*3];
  endsequence
  sequence seq_close;
    cyc_done ##1 !cyc_done;
  endsequence
  chk_min_active: assert property (seq_open |-> seq_hold3)
    else $error("card cycle shorter than three clocks");
  chk_close_done: assert property ($rose(buffer_enable_n) |-> seq_close)
    else $error("cycle end without a single done pulse");
  chk_idle_quiet: assert property (!cyc_busy |-> buffer_enable_n
    && byte_select_n == 2'b11)
    else $error("buffers or selects active while idle");
  chk_dir_idle: assert property (buffer_enable_n |-> !buffer_direction)
    else $error("direction toward card outside an access");
  chk_select_on: assert property (!buffer_enable_n |-> byte_select_n != 2'b11)
    else $error("access without any byte select");
  chk_wait_hold: assert property (!buffer_enable_n && !card_wait_n
    |=> !cyc_done)
    else $error("cycle ended while card held wait");
  chk_strobe_float: assert property (supply_low_en_n && supply_high_en_n
    |-> !mem_rd_strobe_oe && !mem_wr_strobe_oe)
    else $error("strobe driven into unpowered socket");
  chk_irq_ready: assert property (card_ready_busy |-> !card_irq)
    else $error("interrupt raised while card line high");
  chk_miss_quiet: assert property (cyc_miss |-> buffer_enable_n && !cyc_done)
    else $error("refused request still opened a cycle");
endmodule
bind pcs_socket_if pcs_socket_monitor u_mon (.clock(clock), .rst_n(rst_n),
  .cyc_busy(cyc_busy), .cyc_done(cyc_done), .cyc_miss(cyc_miss),
  .buffer_enable_n(buffer_enable_n), .buffer_direction(buffer_direction),
  .byte_select_n(byte_select_n), .mem_rd_strobe_oe(mem_rd_strobe_oe),
  .mem_wr_strobe_oe(mem_wr_strobe_oe), .card_ready_busy(card_ready_busy),
  .card_wait_n(card_wait_n), .card_irq(card_irq),
  .supply_low_en_n(supply_low_en_n), .supply_high_en_n(supply_high_en_n));

/* verif/pcs_card_model.sv */
// Purpose: behavioural card sitting in the socket
// Assumes: card always present; powered for every bench cycle except the last one in t_io, which is refused
// Notes: wait starts on the second clock of an access, as a slow card
`timescale 1ns/10ps
module pcs_card_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic buffer_enable_n,
  input wire logic [3:0] wait_len,
  input wire logic busy_low,
  input wire logic wp_in,
  output logic [2:0] card_detect_in,
  output logic card_ready_busy,
  output logic write_protect_in,
  output logic [1:0] voltage_sense,
  output logic card_wait_n
);
  logic [3:0] left;
  logic was_off;
  assign card_detect_in = 3'b000;
  assign card_ready_busy = !busy_low;
  assign write_protect_in = wp_in;
  assign voltage_sense = 2'b10;
  assign card_wait_n = (left == 4'h0);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left <= 4'h0;
      was_off <= 1'b1;
    end else begin
      was_off <= buffer_enable_n;
      if (was_off && !buffer_enable_n) begin
        left <= wait_len;
      end else if (left != 4'h0) begin
        left <= left - 4'h1;
      end
    end
  end
endmodule

/* verif/pcs_socket_if_tb.sv */
// Purpose: self-checking bench for the card socket interface
// Assumes: clk_en high except in the freeze check, card model in the socket
// Notes: cycle lengths follow from the wait settings written
`timescale 1ns/10ps
module pcs_socket_if_tb
  import pcs_pkg::*;
;
  logic clock, rst_n, io_rd, io_wr, cyc_req, cyc_busy, cyc_done, cyc_miss;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, v, card_upper_addr_mid;
  pcs_cyc_req_t cyc_info;
  logic [3:0] sys_upper_in, sys_upper_addr, wait_len;
  logic [11:0] sys_low_addr;
  logic [1:0] card_upper_addr_hi, byte_select_n, voltage_sense, bs;
  logic buffer_enable_n, buffer_direction, attr_space_select_n, busy_low;
  logic mem_rd_strobe_out, mem_rd_strobe_oe, mem_wr_strobe_out, dir, miss;
  logic mem_wr_strobe_oe, card_reset_out, card_ready_busy, card_irq;
  logic write_protect_in, card_wait_n, supply_low_en_n, supply_high_en_n;
  logic prog_voltage_en, clk_en, wp_in;
  logic [3:0] sb;
  logic [2:0] card_detect_in;
  int num_errors, n_checks, n;
  pcs_socket_if u_dut (.clock, .rst_n, .clk_en, .io_addr, .io_wdata,
    .io_rd, .io_wr, .io_rdata, .cyc_req, .cyc_info, .cyc_busy, .cyc_done,
    .cyc_miss, .sys_upper_in, .sys_upper_addr, .sys_low_addr,
    .card_upper_addr_hi, .card_upper_addr_mid, .buffer_enable_n,
    .buffer_direction, .byte_select_n, .attr_space_select_n,
    .mem_rd_strobe_out, .mem_rd_strobe_oe, .mem_wr_strobe_out,
    .mem_wr_strobe_oe, .card_detect_in, .card_reset_out, .card_ready_busy,
    .write_protect_in, .voltage_sense, .card_wait_n, .card_irq,
    .supply_low_en_n, .supply_high_en_n, .prog_voltage_en);
  pcs_card_model u_card (.clock, .rst_n, .buffer_enable_n, .wait_len,
    .busy_low, .wp_in, .card_detect_in, .card_ready_busy, .write_protect_in,
    .voltage_sense, .card_wait_n);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle clock between port accesses keeps each strobe a clean level
  task io(input logic [15:0] a, input logic [7:0] d, input logic r);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_rd <= r;
    io_wr <= !r;
    @(posedge clock);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    #1;
  endtask
  task wr(input logic [7:0] ix, input logic [7:0] d);
    io(PCS_PORT_INDEX, ix, 1'b0);
    io(PCS_PORT_DATA, d, 1'b0);
  endtask
  task rd(input logic [7:0] ix);
    io(PCS_PORT_INDEX, ix, 1'b0);
    io(PCS_PORT_DATA, 8'h00, 1'b1);
    v = io_rdata;
  endtask
  // counts clocks with buffers enabled; bounded in case done never comes
  task run(input logic [19:0] a, input logic ioc, input logic w);
    int i;
    n = 0;
    miss = 1'b0;
    bs = 2'b11;
    dir = 1'b0;
    sb = 4'h0;
    @(posedge clock);
    cyc_req <= 1'b1;
    cyc_info <= '{addr: a, io: ioc, write: w};
    @(posedge clock);
    cyc_req <= 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if (cyc_miss === 1'b1) miss = 1'b1;
      if (buffer_enable_n === 1'b0) begin
        n++;
        bs = byte_select_n;
        dir = buffer_direction;
        sb = {cyc_busy, attr_space_select_n, mem_rd_strobe_out,
              mem_wr_strobe_out};
      end else if (cyc_done === 1'b1 || miss) break;
      @(posedge clock);
    end
    @(posedge clock);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk({supply_high_en_n, supply_low_en_n}, 2'b11);
    chk(card_reset_out, 1'b1);
    chk(byte_select_n, 2'b11);
    chk(attr_space_select_n, 1'b1);
    @(posedge clock);
    rst_n <= 1'b1;
    rd(PCS_IX_IDENT);
    chk(v, PCS_IDENT_VALUE);
    rd(8'h40);
    chk(v, PCS_UNMAPPED);
    rd(PCS_IX_WAIT);
    chk(v, PCS_RST_WAIT);
    $display("reset test done");
  endtask
  task t_regs;
    wr(PCS_IX_POWER, 8'h22);
    wr(PCS_IX_ROUTE, 8'h10);
    chk({supply_high_en_n, supply_low_en_n}, 2'b10);
    chk(card_reset_out, 1'b0);
    chk(prog_voltage_en, 1'b0);
    chk(mem_rd_strobe_oe, 1'b1);
    rd(PCS_IX_STATUS);
    chk(v[5:0], 6'h3b);
    rd(PCS_IX_CHANGE);
    chk(v, 8'h01);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(PCS_IX_CHANGE, 8'h01);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(PCS_IX_CHANGE);
    chk(v, 8'h01);
    wr(PCS_IX_CHANGE, 8'h01);
    rd(PCS_IX_CHANGE);
    chk(v, 8'h00);
    rd(PCS_IX_VSENSE);
    chk(v[1:0], 2'b10);
    $display("register test done");
  endtask
  task t_mem;
    wr(PCS_IX_WIN_CTL, 8'h01);
    wr(PCS_IX_WIN_OFF_LO, 8'h05);
    wr(PCS_IX_WIN_OFF_HI, 8'h21);
    run(20'ha_0123, 1'b0, 1'b0);
    chk(n, 6);
    chk(bs, 2'b01);
    chk(sb, 4'hd);
    chk({card_upper_addr_hi, card_upper_addr_mid}, 10'h2a5);
    chk(sys_low_addr, 12'h123);
    chk(sys_upper_addr, 4'h9);
    wr(PCS_IX_ROUTE, 8'h1f);
    chk(sys_upper_addr, 4'h1);
    wr(PCS_IX_WAIT, 8'h00);
    run(20'ha_0ffe, 1'b0, 1'b0);
    chk(n, 3);
    chk(bs, 2'b10);
    chk(sys_low_addr, 12'hffe);
    rd(PCS_IX_STATUS);
    chk(v[4], 1'b0);
    run(20'hb_0000, 1'b0, 1'b0);
    chk({miss, n[3:0]}, 5'h10);
    wr(PCS_IX_WIN_STOP, 8'hb0);
    run(20'hb_0000, 1'b0, 1'b0);
    chk({miss, n[3:0]}, 5'h03);
    $display("memory test done");
  endtask
  task t_wide;
    wr(PCS_IX_WIN_CTL, 8'h53);
    run(20'ha_0124, 1'b0, 1'b1);
    chk(n, 8);
    chk(bs, 2'b00);
    chk(dir, 1'b1);
    chk(sb, 4'he);
    wr(PCS_IX_WIN_CTL, 8'h05);
    @(posedge clock);
    wait_len <= 4'h8;
    run(20'ha_0124, 1'b0, 1'b0);
    // wait rises at the second active clock and lasts wait_len clocks
    chk(n, 10);
    chk(sb, 4'h9);
    wait_len <= 4'h0;
    $display("wide and wait test done");
  endtask
  task t_io;
    run(20'h0_03e8, 1'b1, 1'b0);
    chk(n, 3);
    chk(bs, 2'b10);
    chk(sb, 4'hf);
    wr(PCS_IX_POWER, 8'h32);
    @(posedge clock);
    busy_low <= 1'b1;
    @(posedge clock);
    #1;
    chk(card_irq, 1'b1);
    @(posedge clock);
    wp_in <= 1'b1;
    run(20'h0_03e8, 1'b1, 1'b0);
    chk(n, 3);
    chk(bs, 2'b00);
    wp_in <= 1'b0;
    wr(PCS_IX_POWER, 8'h07);
    chk(prog_voltage_en, 1'b1);
    chk(mem_rd_strobe_oe, 1'b0);
    run(20'ha_0124, 1'b0, 1'b0);
    chk(miss, 1'b1);
    $display("io test done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    cyc_req = 1'b0;
    cyc_info = '0;
    sys_upper_in = 4'h9;
    wait_len = 4'h0;
    busy_low = 1'b0;
    clk_en = 1'b1;
    wp_in = 1'b0;
    repeat (16) @(posedge clock);
    t_reset();
    t_regs();
    t_mem();
    t_wide();
    t_io();
    finish_test();
  end
  // whole run is well under a thousand clocks
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    finish_test();
  end
endmodule
